// ===== pfb_pkg.sv
/*
 package for the parallel flash bus host: pin and request carriers,
 controller states, bus widths and timing counts at the 100 MHz clock.
 assumes one clock of 10 ns period shared by every user of the package.
*/
package pfb_pkg;

   localparam int CLK_NS = 10;
   localparam int ADDR_W = 19;
   localparam int DQ_W = 16;
   localparam int BYTE_W = 8;
   localparam int SYNC_W = 17;
   localparam int CNT_W = 16;

   ////////////////////////////////////////////////////////////////////////
   // timing figures in ns; the flash speed grade is not fixed here,
   // so these are plain defaults for a slow part
   localparam int CS_ACCESS_NS = 120;
   localparam int MIN_RESET_PULSE_NS = 500;
   localparam int RESET_RECOVERY_NS = 20000;
   localparam int READ_AFTER_RESET_NS = 50;
   localparam int WRITE_PULSE_NS = 50;
   localparam int SYNC_STAGES = 2;

   // least times round up to whole cycles
   localparam logic [CNT_W-1:0] CS_ACC_CYC =
      CNT_W'((CS_ACCESS_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RST_PULSE_CYC =
      CNT_W'((MIN_RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RECOVERY_CYC =
      CNT_W'((RESET_RECOVERY_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] RH_CYC =
      CNT_W'((READ_AFTER_RESET_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [CNT_W-1:0] WP_CYC =
      CNT_W'((WRITE_PULSE_NS + CLK_NS - 1) / CLK_NS);
   // read waits out the access time plus the input synchroniser and one
   // cycle of margin
   localparam logic [CNT_W-1:0] RD_CYC =
      CS_ACC_CYC + CNT_W'(SYNC_STAGES + 1);

   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      ST_RST_LOW,
      ST_RST_RDY,
      ST_RST_HOLD,
      ST_IDLE,
      ST_RD_ACC,
      ST_WR_SETUP,
      ST_WR_PULSE,
      ST_WR_HOLD,
      ST_WR_END
   } pfb_state_t;

   typedef struct packed {
      logic cs_n;
      logic oe_n;
      logic we_n;
      logic rst_n;
      logic byte_n;
      logic [ADDR_W-1:0] addr;
      logic [DQ_W-1:0] dq_o;
      logic [DQ_W-1:0] dq_oe;
   } pfb_pins_t;

   // addr[0] is the byte lane in byte mode; word mode uses addr[18:0]
   typedef struct packed {
      logic write;
      logic [ADDR_W:0] addr;
      logic [DQ_W-1:0] wdata;
   } pfb_req_t;

endpackage

// ===== pfb_sync.sv
/*
 two flip-flop synchroniser, one stage pair per bit.
 assumes inputs arrive from outside the i_ref_clk domain.
*/
module pfb_sync #(
   parameter int W = 1
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);

   logic [W-1:0] meta;

   genvar g;
   generate
      for (g = 0; g < W; g++)
      begin : g_bit
         always_ff @(posedge i_ref_clk)
         begin
            if (i_sys_rst)
            begin
               meta[g] <= 1'b0;
               o_sync[g] <= 1'b0;
            end
            else
            begin
               meta[g] <= i_async[g];
               o_sync[g] <= meta[g];
            end
         end
      end
   endgenerate

endmodule // pfb_sync

// ===== pfb_host.sv
/*
 host controller for a clockless parallel NOR flash: turns user read,
 write and reset requests into chip select, output gate, write strobe,
 reset and width select levels, and returns read data.
 assumes the flash pins are wired through a testbench or pad that
 resolves dq from o_flash.dq_o and o_flash.dq_oe; dq and ready_busy_n
 arrive asynchronously.
*/
// Behaviour
// - read: select and gate low, strobe high
// - write: select and strobe low, gate high
// - after standby wait full select access time
// - flag an operation cut by reset on o_aborted, no restart
// - wait after reset before first read
module pfb_host (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_req_valid,
   input wire pfb_pkg::pfb_req_t i_req,
   input wire logic i_byte_mode,
   input wire logic i_reset_req,
   input wire logic [pfb_pkg::DQ_W-1:0] i_flash_dq,
   input wire logic i_ready_busy_n,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [pfb_pkg::DQ_W-1:0] o_rsp_data,
   output logic o_flash_busy,
   output logic o_aborted,
   output pfb_pkg::pfb_pins_t o_flash
);

   pfb_pkg::pfb_state_t state, next_state;
   pfb_pkg::pfb_pins_t next_flash;
   logic [pfb_pkg::CNT_W-1:0] cnt, next_cnt;
   logic next_req_ready, next_rsp_valid, next_aborted, next_flash_busy;
   logic [pfb_pkg::DQ_W-1:0] next_rsp_data;
   logic [pfb_pkg::SYNC_W-1:0] sync_in, sync_out;
   logic [pfb_pkg::DQ_W-1:0] dq_s;
   logic rb_s;

   ////////////////////////////////////////////////////////////////////////
   assign sync_in = {i_ready_busy_n, i_flash_dq};

   pfb_sync #(
      .W(pfb_pkg::SYNC_W)
   ) u_sync (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(sync_in),
      .o_sync(sync_out)
   );

   assign dq_s = sync_out[pfb_pkg::DQ_W-1:0];
   assign rb_s = sync_out[pfb_pkg::DQ_W];

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      next_state = state;
      next_cnt = cnt + pfb_pkg::CNT_ONE;
      next_flash = o_flash;
      next_req_ready = o_req_ready;
      next_rsp_valid = 1'b0;
      next_rsp_data = o_rsp_data;
      next_aborted = o_aborted;
      next_flash_busy = ~rb_s;
      unique case (state)
         // reset low floats the bus and deselects: standby throughout
         pfb_pkg::ST_RST_LOW:
         begin
            if (cnt >= pfb_pkg::RST_PULSE_CYC - pfb_pkg::CNT_ONE)
            begin
               next_state = pfb_pkg::ST_RST_RDY;
               next_cnt = '0;
            end
         end
         // hold reset until busy clears or the recovery time runs out
         pfb_pkg::ST_RST_RDY:
         begin
            if (rb_s || cnt >= pfb_pkg::RECOVERY_CYC - pfb_pkg::CNT_ONE)
            begin
               next_flash.rst_n = 1'b1;
               next_state = pfb_pkg::ST_RST_HOLD;
               next_cnt = '0;
            end
         end
         pfb_pkg::ST_RST_HOLD:
         begin
            if (cnt >= pfb_pkg::RH_CYC - pfb_pkg::CNT_ONE)
            begin
               next_state = pfb_pkg::ST_IDLE;
               next_req_ready = 1'b1;
            end
         end
         pfb_pkg::ST_IDLE:
         begin
            next_cnt = '0;
            if (i_reset_req)
            begin
               // a busy flash means an operation is about to be cut
               if (!rb_s)
                  next_aborted = 1'b1;
               next_flash.rst_n = 1'b0;
               next_flash.cs_n = 1'b1;
               next_flash.oe_n = 1'b1;
               next_flash.we_n = 1'b1;
               next_flash.dq_oe = '0;
               next_req_ready = 1'b0;
               next_state = pfb_pkg::ST_RST_LOW;
            end
            else if (i_req_valid && o_req_ready)
            begin
               next_aborted = 1'b0;
               next_req_ready = 1'b0;
               next_flash.cs_n = 1'b0;
               next_flash.byte_n = ~i_byte_mode;
               next_flash.dq_oe = '0;
               if (i_byte_mode)
               begin
                  next_flash.addr = i_req.addr[pfb_pkg::ADDR_W:1];
                  next_flash.dq_o[pfb_pkg::DQ_W-1] = i_req.addr[0];
                  next_flash.dq_oe[pfb_pkg::DQ_W-1] = 1'b1;
               end
               else
                  next_flash.addr = i_req.addr[pfb_pkg::ADDR_W-1:0];
               if (i_req.write)
                  next_state = pfb_pkg::ST_WR_SETUP;
               else
               begin
                  next_flash.oe_n = 1'b0;
                  next_state = pfb_pkg::ST_RD_ACC;
               end
               if (i_req.write)
               begin
                  // data goes out with the strobe, not before it
                  next_flash.dq_o[pfb_pkg::BYTE_W-1:0] =
                     i_req.wdata[pfb_pkg::BYTE_W-1:0];
                  if (!i_byte_mode)
                     next_flash.dq_o = i_req.wdata;
               end
            end
         end
         // every access starts from standby, so each pays full access
         pfb_pkg::ST_RD_ACC:
         begin
            if (cnt >= pfb_pkg::RD_CYC - pfb_pkg::CNT_ONE)
            begin
               next_rsp_valid = 1'b1;
               next_rsp_data = o_flash.byte_n ? dq_s :
                  {{(pfb_pkg::DQ_W-pfb_pkg::BYTE_W){1'b0}},
                   dq_s[pfb_pkg::BYTE_W-1:0]};
               next_flash.oe_n = 1'b1;
               next_flash.cs_n = 1'b1;
               next_flash.dq_oe = '0;
               next_req_ready = 1'b1;
               next_state = pfb_pkg::ST_IDLE;
            end
         end
         pfb_pkg::ST_WR_SETUP:
         begin
            next_flash.we_n = 1'b0;
            next_flash.dq_oe[pfb_pkg::BYTE_W-1:0] = '1;
            if (o_flash.byte_n)
               next_flash.dq_oe = '1;
            next_cnt = '0;
            next_state = pfb_pkg::ST_WR_PULSE;
         end
         pfb_pkg::ST_WR_PULSE:
         begin
            if (cnt >= pfb_pkg::WP_CYC - pfb_pkg::CNT_ONE)
            begin
               // strobe rises first so the data edge is the strobe's
               next_flash.we_n = 1'b1;
               next_state = pfb_pkg::ST_WR_HOLD;
            end
         end
         pfb_pkg::ST_WR_HOLD:
         begin
            next_flash.cs_n = 1'b1;
            next_state = pfb_pkg::ST_WR_END;
         end
         pfb_pkg::ST_WR_END:
         begin
            next_flash.dq_oe = '0;
            next_rsp_valid = 1'b1;
            next_req_ready = 1'b1;
            next_state = pfb_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         // power-up pulses reset so the flash starts in read-array mode
         state <= pfb_pkg::ST_RST_LOW;
         cnt <= '0;
         o_flash <= '{cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b0,
                      byte_n: 1'b1, addr: '0, dq_o: '0, dq_oe: '0};
         o_req_ready <= 1'b0;
         o_rsp_valid <= 1'b0;
         o_rsp_data <= '0;
         o_aborted <= 1'b0;
         o_flash_busy <= 1'b0;
      end
      else
      begin
         state <= next_state;
         cnt <= next_cnt;
         o_flash <= next_flash;
         o_req_ready <= next_req_ready;
         o_rsp_valid <= next_rsp_valid;
         o_rsp_data <= next_rsp_data;
         o_aborted <= next_aborted;
         o_flash_busy <= next_flash_busy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // helper counters read only by the checks below
   logic [pfb_pkg::CNT_W-1:0] rst_lo_cnt, since_rst_cnt, cs_lo_cnt;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         rst_lo_cnt <= '0;
         since_rst_cnt <= '0;
         cs_lo_cnt <= '0;
      end
      else
      begin
         rst_lo_cnt <= o_flash.rst_n ? '0 :
            (rst_lo_cnt == pfb_pkg::CNT_MAX ? rst_lo_cnt :
             rst_lo_cnt + pfb_pkg::CNT_ONE);
         since_rst_cnt <= !o_flash.rst_n ? '0 :
            (since_rst_cnt == pfb_pkg::CNT_MAX ? since_rst_cnt :
             since_rst_cnt + pfb_pkg::CNT_ONE);
         cs_lo_cnt <= o_flash.cs_n ? '0 :
            (cs_lo_cnt == pfb_pkg::CNT_MAX ? cs_lo_cnt :
             cs_lo_cnt + pfb_pkg::CNT_ONE);
      end
   end

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);

   read_levels_a: assert property (
      !o_flash.oe_n |-> !o_flash.cs_n && o_flash.we_n && o_flash.rst_n)
      else $error("read gate low without select, strobe high, reset high");
   write_levels_a: assert property (
      !o_flash.we_n |-> !o_flash.cs_n && o_flash.oe_n)
      else $error("write strobe low without select low and gate high");
   read_bus_free_a: assert property (
      !o_flash.oe_n |-> o_flash.dq_oe[pfb_pkg::DQ_W-2:0] == '0)
      else $error("host drives data lines during a read");
   byte_hiz_a: assert property (
      !o_flash.byte_n |->
         o_flash.dq_oe[pfb_pkg::DQ_W-2:pfb_pkg::BYTE_W] == '0)
      else $error("middle data lines driven in byte mode");
   byte_lsb_a: assert property (
      !o_flash.byte_n && !o_flash.cs_n |-> o_flash.dq_oe[pfb_pkg::DQ_W-1])
      else $error("byte lane address not driven in byte mode");
   word_write_a: assert property (
      o_flash.byte_n && !o_flash.we_n |-> o_flash.dq_oe == '1)
      else $error("word write does not drive all sixteen lines");
   reset_pulse_a: assert property (
      $rose(o_flash.rst_n) |-> $past(rst_lo_cnt) >= pfb_pkg::RST_PULSE_CYC)
      else $error("reset pulse shorter than the minimum");
   reset_standby_a: assert property (
      !o_flash.rst_n |-> o_flash.cs_n && o_flash.dq_oe == '0)
      else $error("bus not idle while reset is low");
   reset_ready_a: assert property (
      $rose(o_flash.rst_n) |->
         $past(rb_s) || $past(rst_lo_cnt) >= pfb_pkg::RECOVERY_CYC)
      else $error("reset released while busy before recovery time");
   read_after_rst_a: assert property (
      $fell(o_flash.oe_n) |-> since_rst_cnt >= pfb_pkg::RH_CYC)
      else $error("read started too soon after reset release");
   access_time_a: assert property (
      o_rsp_valid && $past(state) == pfb_pkg::ST_RD_ACC |->
         $past(cs_lo_cnt) >= pfb_pkg::CS_ACC_CYC)
      else $error("read data taken before select access time");
   abort_flag_a: assert property (
      state == pfb_pkg::ST_IDLE && i_reset_req && !rb_s |=> o_aborted)
      else $error("reset of a busy flash not flagged");

   read_done_c: cover property (
      $fell(o_flash.oe_n) ##[1:40] o_rsp_valid);
   write_done_c: cover property (
      $fell(o_flash.we_n) ##[1:20] o_rsp_valid);
   byte_read_c: cover property (
      !o_flash.byte_n && !o_flash.oe_n ##[1:40] o_rsp_valid);
   busy_reset_c: cover property (
      state == pfb_pkg::ST_IDLE && i_reset_req && !rb_s);

endmodule // pfb_host

// ===== pfb_flash_model.sv
/*
 behavioural flash device for the host bench: array, command latch,
 autoselect, program, sector erase, status, reset and ready pin.
 assumes the bench resolves the dq lines and feeds them back here.
*/
module pfb_flash_model #(
   parameter int PROG_NS = 5000,
   parameter int REC_NS = 3000,
   parameter logic [15:0] CMD_READ = 16'h00F0,
   parameter logic [15:0] CMD_AUTO = 16'h0090,
   parameter logic [15:0] CMD_PROG = 16'h00A0,
   parameter logic [15:0] CMD_ERASE = 16'h0030,
   parameter logic [7:0] ID_CODE = 8'h3C, // arbitrary value
   parameter logic [7:0] STATUS = 8'h4B
) (
   input wire pfb_pkg::pfb_pins_t i_pins,
   input wire logic [15:0] i_dq,
   output logic [15:0] o_dq,
   output logic [15:0] o_dq_en,
   output logic o_ready_busy_n
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] mem [16];
   logic [18:0] cmd_addr;
   logic [15:0] cmd_data, word, val;
   logic auto_md, prog_arm, busy, acc_ok, sel_rd;
   logic [7:0] op_id, sel_id;
   realtime t_rst;
   initial
   begin
      for (int i = 0; i < 16; i++) mem[i] = {8'hC3, 4'h0, 4'(i)};
      auto_md = 0;
      prog_arm = 0;
      busy = 0;
      acc_ok = 0;
      op_id = 8'h00;
      sel_id = 8'h00;
      t_rst = 0;
      o_ready_busy_n = 1;
   end
   //////////////////////////////////////////////////////////////////////
   task automatic start_op(input logic erase);
      logic [7:0] id;
      logic [18:0] a;
      logic [15:0] d;
      begin
         op_id = op_id + 8'h01;
         id = op_id;
         a = cmd_addr;
         d = cmd_data;
         busy = 1;
         o_ready_busy_n = 0;
         fork
            begin
               #(PROG_NS);
               // deselect never reaches here, only a reset cancels it
               if (busy && id == op_id)
               begin
                  if (!erase) mem[a[3:0]] = d;
                  else for (int i = 0; i < 16; i++)
                     if (2'(i >> 2) == a[3:2]) mem[i] = 16'hFFFF;
                  busy = 0;
                  o_ready_busy_n = 1;
               end
            end
         join_none
      end
   endtask
   always @(negedge i_pins.we_n)
      if (!i_pins.cs_n && i_pins.rst_n) cmd_addr = i_pins.addr;
   always @(posedge i_pins.we_n)
      if (!i_pins.cs_n && i_pins.rst_n && !busy)
      begin
         cmd_data = i_pins.byte_n ? i_dq : {8'h00, i_dq[7:0]};
         if (prog_arm)
         begin
            prog_arm = 0;
            start_op(1'b0);
         end
         else if (cmd_data == CMD_PROG) prog_arm = 1;
         else if (cmd_data == CMD_ERASE) start_op(1'b1);
         else if (cmd_data == CMD_AUTO) auto_md = 1;
         else if (cmd_data == CMD_READ) auto_md = 0;
      end
   always @(negedge i_pins.rst_n)
   begin
      op_id = op_id + 8'h01;
      auto_md = 0;
      prog_arm = 0;
      if (busy)
      begin
         busy = 0;
         #(REC_NS);
         o_ready_busy_n = 1;
      end
   end
   always @(posedge i_pins.rst_n) t_rst = $realtime;
   always @(posedge i_pins.cs_n) acc_ok = 0;
   // each select runs its own timer, so a quick reselect cannot inherit
   // the access time left over from the previous cycle
   task automatic arm_access();
      logic [7:0] id;
      realtime t0;
      begin
         sel_id = sel_id + 8'h01;
         id = sel_id;
         t0 = $realtime;
         acc_ok = 0;
         fork
            begin
               #(pfb_pkg::CS_ACCESS_NS);
               if (id == sel_id)
                  acc_ok = !i_pins.cs_n &&
                     (t0 - t_rst >= pfb_pkg::READ_AFTER_RESET_NS);
            end
         join_none
      end
   endtask
   always @(negedge i_pins.cs_n) arm_access();
   always_comb
   begin
      sel_rd = !i_pins.cs_n && !i_pins.oe_n && i_pins.we_n && i_pins.rst_n;
      word = mem[i_pins.addr[3:0]];
      if (busy) val = {8'h00, STATUS};
      else if (auto_md) val = {8'h00, ID_CODE};
      else if (i_pins.byte_n) val = word;
      else val = {8'h00, i_dq[15] ? word[15:8] : word[7:0]};
      // data before the access time is garbage, never a stale match
      o_dq = acc_ok ? val : ~val;
      o_dq_en = !sel_rd ? 16'h0000 :
         i_pins.byte_n ? 16'hFFFF : 16'h00FF;
   end
endmodule // pfb_flash_model

// ===== pfb_host_bench.sv
/*
 self-checking bench for pfb_host against the behavioural flash.
 assumes the package timing defaults and a 100 MHz clock.
*/
`define CHK(nm, ex, got) begin checks_done++; \
   if ((got) !== (ex)) begin bad_count++; \
   $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module pfb_host_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] C_RD = 16'h00F0, C_AU = 16'h0090;
   localparam logic [15:0] C_PG = 16'h00A0, C_ER = 16'h0030;
   localparam logic [7:0] ID = 8'h3C, STAT = 8'h4B; // id value arbitrary
   logic clk, rst, req_valid, byte_mode, reset_req, ready_busy_n;
   logic req_ready, rsp_valid, flash_busy, aborted, seen_byte_n;
   pfb_pkg::pfb_req_t req;
   pfb_pkg::pfb_pins_t pins;
   logic [15:0] rsp_data, rd_data, fl_dq, fl_en, float_pat, flash_dq;
   int bad_count, checks_done;
   // released lines flip every cycle so a stale value cannot match
   assign flash_dq = (pins.dq_oe & pins.dq_o) |
      (~pins.dq_oe & fl_en & fl_dq) | (~pins.dq_oe & ~fl_en & float_pat);
   pfb_host u_pfb_host (.i_ref_clk(clk), .i_sys_rst(rst),
      .i_req_valid(req_valid), .i_req(req), .i_byte_mode(byte_mode),
      .i_reset_req(reset_req), .i_flash_dq(flash_dq),
      .i_ready_busy_n(ready_busy_n), .o_req_ready(req_ready),
      .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
      .o_flash_busy(flash_busy), .o_aborted(aborted), .o_flash(pins));
   pfb_flash_model #(.PROG_NS(5000), .REC_NS(3000), .CMD_READ(C_RD),
      .CMD_AUTO(C_AU), .CMD_PROG(C_PG), .CMD_ERASE(C_ER),
      .ID_CODE(ID), .STATUS(STAT)) u_pfb_flash_model (.i_pins(pins),
      .i_dq(flash_dq), .o_dq(fl_dq), .o_dq_en(fl_en),
      .o_ready_busy_n(ready_busy_n));
   //////////////////////////////////////////////////////////////////////
   initial
   begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) float_pat <= ~float_pat;
   always @(negedge clk)
      if (!rst)
      begin
         `CHK("dq_contention", 16'h0000, pins.dq_oe & fl_en)
         `CHK("strobe_vs_gate", 1'b1, pins.we_n | pins.oe_n)
      end
   function automatic logic [15:0] init_word(input logic [3:0] i);
      return {8'hC3, 4'h0, i};
   endfunction
   task automatic wait_idle();
      int n;
      begin
         n = 0;
         @(negedge clk);
         while (req_ready !== 1'b1 && n < 5000)
         begin
            @(negedge clk);
            n++;
         end
         `CHK("req_ready", 1'b1, req_ready)
      end
   endtask
   task automatic do_req(input logic wr, input logic bm,
      input logic [19:0] a, input logic [15:0] d);
      int n;
      begin
         wait_idle();
         @(posedge clk);
         req_valid <= 1'b1;
         req <= '{write: wr, addr: a, wdata: d};
         byte_mode <= bm;
         @(posedge clk);
         req_valid <= 1'b0;
         @(negedge clk);
         seen_byte_n = pins.byte_n;
         n = 1;
         while (rsp_valid !== 1'b1 && n < 100)
         begin
            @(negedge clk);
            n++;
         end
         rd_data = rsp_data;
         `CHK("rsp_latency", wr ? 9 : 16, n)
      end
   endtask
   task automatic do_reset(input logic exp_abort);
      begin
         wait_idle();
         @(posedge clk);
         reset_req <= 1'b1;
         @(posedge clk);
         reset_req <= 1'b0;
         @(negedge clk);
         `CHK("aborted", exp_abort, aborted)
         `CHK("rst_pin", 1'b0, pins.rst_n)
      end
   endtask
   task automatic wait_busy(input logic lvl);
      int n;
      begin
         n = 0;
         while (flash_busy !== lvl && n < 2000)
         begin
            @(negedge clk);
            n++;
         end
         `CHK("flash_busy", lvl, flash_busy)
      end
   endtask
   //////////////////////////////////////////////////////////////////////
   task automatic t_width();
      begin
         do_req(1'b0, 1'b0, 20'h00003, 16'h0000);
         `CHK("rd_word", init_word(4'h3), rd_data)
         `CHK("byte_n_word", 1'b1, seen_byte_n)
         do_req(1'b0, 1'b1, 20'h0000D, 16'h0000);
         `CHK("rd_byte_hi", 16'h00C3, rd_data)
         `CHK("byte_n_byte", 1'b0, seen_byte_n)
         do_req(1'b0, 1'b1, 20'h0000C, 16'h0000);
         `CHK("rd_byte_lo", 16'h0006, rd_data)
      end
   endtask
   task automatic t_auto();
      begin
         // command written in byte mode: only the low lane carries it
         do_req(1'b1, 1'b1, 20'h00AAA, C_AU);
         `CHK("byte_n_wr", 1'b0, seen_byte_n)
         do_req(1'b0, 1'b0, 20'h00002, 16'h0000);
         `CHK("rd_ident", {8'h00, ID}, rd_data)
         do_req(1'b1, 1'b0, 20'h00555, C_RD);
         do_req(1'b0, 1'b0, 20'h00002, 16'h0000);
         `CHK("rd_back_array", init_word(4'h2), rd_data)
      end
   endtask
   task automatic t_prog_erase();
      begin
         do_req(1'b1, 1'b0, 20'h00005, C_PG);
         do_req(1'b1, 1'b0, 20'h00005, 16'hBEEF);
         do_req(1'b0, 1'b0, 20'h00005, 16'h0000);
         `CHK("rd_status", {8'h00, STAT}, rd_data)
         wait_busy(1'b0);
         do_req(1'b0, 1'b0, 20'h00005, 16'h0000);
         `CHK("rd_programmed", 16'hBEEF, rd_data)
         do_req(1'b1, 1'b0, 20'h00008, C_ER);
         wait_busy(1'b1);
         wait_busy(1'b0);
         do_req(1'b0, 1'b0, 20'h00009, 16'h0000);
         `CHK("rd_erased", 16'hFFFF, rd_data)
         do_req(1'b0, 1'b0, 20'h0000C, 16'h0000);
         `CHK("rd_other_sector", init_word(4'hC), rd_data)
      end
   endtask
   task automatic t_resets();
      begin
         do_req(1'b1, 1'b0, 20'h00001, C_PG);
         do_req(1'b1, 1'b0, 20'h00001, 16'h1234);
         wait_busy(1'b1);
         do_reset(1'b1);
         do_req(1'b0, 1'b0, 20'h00001, 16'h0000);
         `CHK("rd_after_abort", init_word(4'h1), rd_data)
         `CHK("aborted_clear", 1'b0, aborted)
         do_req(1'b1, 1'b0, 20'h00555, C_AU);
         do_reset(1'b0);
         do_req(1'b0, 1'b0, 20'h00002, 16'h0000);
         `CHK("rd_idle_reset", init_word(4'h2), rd_data)
      end
   endtask
   task automatic close_out();
      begin
         $display("checks %0d errors %0d", checks_done, bad_count);
         if (bad_count == 0 && checks_done > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   initial
   begin
      rst = 1;
      req_valid = 0;
      req = '0;
      byte_mode = 0;
      reset_req = 0;
      float_pat = 16'h5A5A;
      bad_count = 0;
      checks_done = 0;
      repeat (3) @(posedge clk);
      rst <= 0;
      t_width();
      t_auto();
      t_prog_erase();
      t_resets();
      close_out();
   end
   initial
   begin
      #200000;
      bad_count++;
      $display("ERROR watchdog expected done seen timeout");
      close_out();
   end
endmodule // pfb_host_bench
